// ---- pkg/adcr_consts.svh ----
/*
  register offsets, field positions, widths and reset values of the converter
  control registers; assumes byte addresses on a 32-bit peripheral bus.
*/
`ifndef ADCR_CONSTS_SVH
`define ADCR_CONSTS_SVH

// register byte offsets
`define ADCR_OFS_MODE        12'h004
`define ADCR_OFS_CHAN_ENA    12'h010
`define ADCR_OFS_CHAN_DIS    12'h014
`define ADCR_OFS_CHAN_STAT   12'h018
`define ADCR_OFS_STATUS      12'h01C
`define ADCR_OFS_LAST_DATA   12'h020
`define ADCR_OFS_IRQ_ENA     12'h024
`define ADCR_OFS_IRQ_DIS     12'h028
`define ADCR_OFS_IRQ_MASK    12'h02C
`define ADCR_OFS_RESULT_BASE 12'h040
`define ADCR_OFS_RESULT_LAST 12'h05C

// widths
`define ADCR_ADDR_W          12
`define ADCR_NUM_CHAN        8
`define ADCR_CHAN_W          3
`define ADCR_DATA_W          10
`define ADCR_LOW_W           8
`define ADCR_FLAG_W          20

// status, enable, disable and mask field positions
`define ADCR_POS_DONE_LSB    0
`define ADCR_POS_OVR_LSB     8
`define ADCR_POS_RDY         16
`define ADCR_POS_GOVR        17
`define ADCR_POS_RXEND       18
`define ADCR_POS_RXFULL      19

// mode register field
`define ADCR_POS_RES_SEL     4

// reset values
`define ADCR_RST_CHAN_EN     8'h00
`define ADCR_RST_MASK        20'h00000
`define ADCR_RST_RES_SEL     1'h0
`define ADCR_RST_DATA        10'h000

`endif

// ---- pkg/adcr_pkg.sv ----
/*
  state types of the converter control block and its result memory;
  assumes adcr_consts.svh is on the include path.
*/
`include "adcr_consts.svh"

package adcr_pkg;

  typedef struct packed {
    logic [`ADCR_NUM_CHAN-1:0] chan_en;
    logic                      res_sel;
    logic [`ADCR_FLAG_W-1:0]   mask;
    logic [`ADCR_NUM_CHAN-1:0] done_flag;
    logic [`ADCR_NUM_CHAN-1:0] ovr_flag;
    logic                      rdy_flag;
    logic                      govr_flag;
    logic [`ADCR_DATA_W-1:0]   last_data;
    logic                      pready;
    logic                      pslverr;
    logic [31:0]               prdata;
    logic                      irq;
  } adcr_state_t;

  typedef struct packed {
    logic [`ADCR_NUM_CHAN-1:0][`ADCR_DATA_W-1:0] words;
    logic [`ADCR_DATA_W-1:0]                     rdata;
  } adcr_mem_state_t;

endpackage

// ---- design/adcr_result_mem.sv ----
/*
  eight-word per-channel result store, one write and one read port, read data
  registered; assumes a single clock and that en freezes it entirely.
*/
`timescale 1ns/1ps
`include "adcr_consts.svh"

module adcr_result_mem (
  // clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     en,
  // write port
  input  wire logic                     we,
  input  wire logic [`ADCR_CHAN_W-1:0]  waddr,
  input  wire logic [`ADCR_DATA_W-1:0]  wdata,
  // read port
  input  wire logic                     re,
  input  wire logic [`ADCR_CHAN_W-1:0]  raddr,
  output logic      [`ADCR_DATA_W-1:0]  rdata
);

  adcr_pkg::adcr_mem_state_t s_q;
  adcr_pkg::adcr_mem_state_t s_d;

  always_comb
  begin
    s_d = s_q;
    // read before write: a same-cycle load is seen on the next read
    if (re)
    begin
      s_d.rdata = s_q.words[raddr];
    end
    if (we)
    begin
      s_d.words[waddr] = wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
    end
    else if (en)
    begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;

endmodule

// ---- design/adcr_top.sv ----
/*
  register side of an eight-channel converter controller: APB slave, channel
  enables, resolution select, status flags, interrupt enable/disable/mask,
  per-channel result registers and the interrupt output.
  assumes the conversion engine and the receive DMA run on pclk, so their
  strobes and levels are used without synchronisers.
*/
`timescale 1ns/1ps
`include "adcr_consts.svh"

module adcr_top (
  // clock, reset, clock enable
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       clk_en,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [`ADCR_ADDR_W-1:0]    paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // conversion engine
  input  wire logic                       conv_end,
  input  wire logic [`ADCR_CHAN_W-1:0]    conv_chan,
  input  wire logic [`ADCR_DATA_W-1:0]    conv_value,
  // receive dma status levels
  input  wire logic                       receive_count_end_flag,
  input  wire logic                       receive_buffers_full_flag,
  // controls towards the engine
  output logic      [`ADCR_NUM_CHAN-1:0]  channel_enable_bit,
  output logic                            resolution_select,
  // interrupt
  output logic                            irq
);

  adcr_pkg::adcr_state_t s_q;
  adcr_pkg::adcr_state_t s_d;

  logic                      setup_ph;
  logic                      access_ph;
  logic                      xfer_done;
  logic                      wr_done;
  logic                      rd_done;
  logic                      is_result;
  logic [`ADCR_CHAN_W-1:0]   result_idx;
  logic                      load_ok;
  logic [`ADCR_DATA_W-1:0]   load_value;
  logic [`ADCR_DATA_W-1:0]   mem_rdata;
  logic [`ADCR_FLAG_W-1:0]   status_now;

  assign setup_ph   = psel & ~penable;
  assign access_ph  = psel & penable;
  assign xfer_done  = access_ph & s_q.pready;
  assign wr_done    = xfer_done & pwrite;
  assign rd_done    = xfer_done & ~pwrite;
  assign is_result  = (paddr >= `ADCR_OFS_RESULT_BASE) && (paddr <= `ADCR_OFS_RESULT_LAST)
                      && (paddr[1:0] == 2'h0);
  assign result_idx = paddr[4:2];

  assign load_ok    = conv_end & s_q.chan_en[conv_chan];
  // in low resolution only the right-aligned low byte is meaningful
  assign load_value = s_q.res_sel ? {2'h0, conv_value[`ADCR_LOW_W-1:0]} : conv_value;

  // channel results live in a small memory; its read is issued in the setup cycle
  adcr_result_mem u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .en      (clk_en),
    .we      (load_ok),
    .waddr   (conv_chan),
    .wdata   (load_value),
    .re      (setup_ph & is_result),
    .raddr   (result_idx),
    .rdata   (mem_rdata)
  );

  function automatic logic [`ADCR_FLAG_W-1:0] pack_status(
    input logic [`ADCR_NUM_CHAN-1:0] done_f,
    input logic [`ADCR_NUM_CHAN-1:0] ovr_f,
    input logic                      rdy_f,
    input logic                      govr_f,
    input logic                      rxend_f,
    input logic                      rxfull_f
  );
    logic [`ADCR_FLAG_W-1:0] v;
    v = '0;
    v[`ADCR_POS_DONE_LSB +: `ADCR_NUM_CHAN] = done_f;
    v[`ADCR_POS_OVR_LSB +: `ADCR_NUM_CHAN]  = ovr_f;
    v[`ADCR_POS_RDY]    = rdy_f;
    v[`ADCR_POS_GOVR]   = govr_f;
    v[`ADCR_POS_RXEND]  = rxend_f;
    v[`ADCR_POS_RXFULL] = rxfull_f;
    return v;
  endfunction

  // the live rx levels go in as arguments so every caller re-evaluates when they move
  assign status_now  = pack_status(s_q.done_flag, s_q.ovr_flag, s_q.rdy_flag, s_q.govr_flag,
                                   receive_count_end_flag, receive_buffers_full_flag);

  always_comb
  begin
    s_d = s_q;

    // one wait state: data of the memory read are ready in the first access cycle
    s_d.pready  = access_ph & ~s_q.pready;
    if (access_ph && !s_q.pready)
    begin
      s_d.pslverr = 1'b0;
      s_d.prdata  = 32'h0000_0000;
      if (paddr == `ADCR_OFS_MODE)
      begin
        s_d.prdata[`ADCR_POS_RES_SEL] = s_q.res_sel;
      end
      else if (paddr == `ADCR_OFS_CHAN_STAT)
      begin
        s_d.prdata[`ADCR_NUM_CHAN-1:0] = s_q.chan_en;
      end
      else if (paddr == `ADCR_OFS_STATUS)
      begin
        s_d.prdata[`ADCR_FLAG_W-1:0] = status_now;
      end
      else if (paddr == `ADCR_OFS_LAST_DATA)
      begin
        s_d.prdata[`ADCR_DATA_W-1:0] = s_q.last_data;
      end
      else if (paddr == `ADCR_OFS_IRQ_MASK)
      begin
        s_d.prdata[`ADCR_FLAG_W-1:0] = s_q.mask;
      end
      else if (is_result)
      begin
        s_d.prdata[`ADCR_DATA_W-1:0] = mem_rdata;
      end
      else if ((paddr == `ADCR_OFS_CHAN_ENA) || (paddr == `ADCR_OFS_CHAN_DIS)
               || (paddr == `ADCR_OFS_IRQ_ENA) || (paddr == `ADCR_OFS_IRQ_DIS))
      begin
        s_d.prdata = 32'h0000_0000;
      end
      else
      begin
        s_d.pslverr = 1'b1;
      end
    end
    else
    begin
      // answer stands one cycle only; idle bus data reads as zero
      s_d.pslverr = 1'b0;
      s_d.prdata  = 32'h0000_0000;
    end

    // register writes take effect at the completing edge
    if (wr_done)
    begin
      if (paddr == `ADCR_OFS_MODE)
      begin
        s_d.res_sel = pwdata[`ADCR_POS_RES_SEL];
      end
      else if (paddr == `ADCR_OFS_CHAN_ENA)
      begin
        s_d.chan_en = s_q.chan_en | pwdata[`ADCR_NUM_CHAN-1:0];
      end
      else if (paddr == `ADCR_OFS_CHAN_DIS)
      begin
        s_d.chan_en = s_q.chan_en & ~pwdata[`ADCR_NUM_CHAN-1:0];
      end
      else if (paddr == `ADCR_OFS_IRQ_ENA)
      begin
        s_d.mask = s_q.mask | pwdata[`ADCR_FLAG_W-1:0];
      end
      else if (paddr == `ADCR_OFS_IRQ_DIS)
      begin
        s_d.mask = s_q.mask & ~pwdata[`ADCR_FLAG_W-1:0];
      end
    end

    // read side effects: clear-on-read flags
    if (rd_done)
    begin
      if (paddr == `ADCR_OFS_STATUS)
      begin
        s_d.ovr_flag  = '0;
        s_d.govr_flag = 1'b0;
      end
      else if (paddr == `ADCR_OFS_LAST_DATA)
      begin
        s_d.rdy_flag = 1'b0;
      end
      else if (is_result)
      begin
        s_d.done_flag[result_idx] = 1'b0;
      end
    end

    // conversion events come last so a set beats a clear in the same cycle
    if (load_ok)
    begin
      s_d.ovr_flag[conv_chan]  = s_d.ovr_flag[conv_chan] | s_q.done_flag[conv_chan];
      s_d.done_flag[conv_chan] = 1'b1;
      s_d.govr_flag            = s_d.govr_flag | s_q.rdy_flag;
      s_d.rdy_flag             = 1'b1;
      s_d.last_data            = load_value;
    end

    s_d.irq = |(pack_status(s_d.done_flag, s_d.ovr_flag, s_d.rdy_flag, s_d.govr_flag,
                            receive_count_end_flag, receive_buffers_full_flag)
                & s_d.mask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q           <= '0;
      s_q.chan_en   <= `ADCR_RST_CHAN_EN;
      s_q.res_sel   <= `ADCR_RST_RES_SEL;
      s_q.mask      <= `ADCR_RST_MASK;
      s_q.last_data <= `ADCR_RST_DATA;
    end
    else if (clk_en)
    begin
      s_q <= s_d;
    end
  end

  assign prdata             = s_q.prdata;
  assign pready             = s_q.pready;
  assign pslverr            = s_q.pslverr;
  assign channel_enable_bit = s_q.chan_en;
  assign resolution_select  = s_q.res_sel;
  assign irq                = s_q.irq;

endmodule

// ---- test/adcr_assertions.sv ----
/*
  checker for adcr_top: apb answer shape, mask and result shadows.
  assumes no conversion lands inside a result read; shadows freeze with clk_en.
*/
`timescale 1ns/1ps
module adcr_assertions (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // engine and controls
  input wire logic        conv_end,
  input wire logic [2:0]  conv_chan,
  input wire logic [9:0]  conv_value,
  input wire logic [7:0]  channel_enable_bit,
  input wire logic        resolution_select,
  input wire logic        irq
);
  logic [19:0]     mask_q;
  logic [7:0][9:0] res_q;
  logic            sel_q;
  wire fin = psel && penable && pready;
  wire wr  = fin && pwrite;
  wire rd  = fin && !pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadows built from port traffic only, never from the body
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      mask_q <= '0;
      res_q  <= '0;
      sel_q  <= 1'h0;
    end
    else if (clk_en)
    begin
      if (wr && paddr == 12'h004)
        sel_q <= pwdata[4];
      if (wr && paddr == 12'h024)
        mask_q <= mask_q | pwdata[19:0];
      if (wr && paddr == 12'h028)
        mask_q <= mask_q & ~pwdata[19:0];
      if (conv_end && channel_enable_bit[conv_chan])
        res_q[conv_chan] <= resolution_select ? {2'h0, conv_value[7:0]} : conv_value;
    end
  chk_ready_wait: assert property (psel && $rose(penable) |=> pready)
    else $error("pready late");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  chk_err_ready: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("pslverr misplaced");
  chk_idle_data: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not idle");
  chk_mask_read: assert property (
    rd && paddr == 12'h02C |-> prdata == {12'h000, mask_q})
    else $error("mask read wrong");
  chk_irq_off: assert property (mask_q == 20'h00000 |-> !irq)
    else $error("irq while all masked");
  chk_res_sel: assert property (resolution_select == sel_q)
    else $error("resolution select wrong");
  chk_result_read: assert property (
    rd && paddr[11:5] == 7'h02 && paddr[1:0] == 2'h0
    |-> prdata == {22'h0, res_q[paddr[4:2]]})
    else $error("result read wrong");
endmodule

bind adcr_top adcr_assertions i_chk (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .conv_end, .conv_chan, .conv_value,
  .channel_enable_bit, .resolution_select, .irq);

// ---- test/adcr_engine_model.sv ----
/*
  conversion engine stand-in: one conv_end pulse per request.
  assumes the same clock as the block.
*/
`timescale 1ns/1ps
module adcr_engine_model (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // bench request
  input wire logic       req,
  input wire logic [2:0] req_chan,
  input wire logic [9:0] req_value,
  // towards the block
  output logic           conv_end,
  output logic [2:0]     conv_chan,
  output logic [9:0]     conv_value
);
  // outside a pulse the channel and value lines flip so a stale result never looks valid
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      conv_end   <= 1'h0;
      conv_chan  <= 3'h0;
      conv_value <= 10'h000;
    end
    else
    begin
      conv_end   <= req;
      conv_chan  <= req ? req_chan : ~conv_chan;
      conv_value <= req ? req_value : ~conv_value;
    end
endmodule

// ---- test/adcr_top_bench.sv ----
/*
  bench for adcr_top: register rows, then conversions, masking, resolution.
  assumes one apb wait state is not relied on; clk_en drops once, off the bus.
*/
`timescale 1ns/1ps
module adcr_top_bench;
  typedef struct packed {
    logic        wr;
    logic [11:0] addr;
    logic [31:0] data;
    logic        err;
  } adcr_row_t;
  localparam adcr_row_t ROWS [12] = '{
    '{1'h0, 12'h02C, 32'h00000000, 1'h0},
    '{1'h1, 12'h024, 32'hFFFFFFFF, 1'h0},
    '{1'h0, 12'h02C, 32'h000FFFFF, 1'h0},
    '{1'h1, 12'h028, 32'h000000FF, 1'h0},
    '{1'h0, 12'h02C, 32'h000FFF00, 1'h0},
    '{1'h1, 12'h028, 32'h000A0000, 1'h0},
    '{1'h0, 12'h028, 32'h00000000, 1'h0},
    '{1'h1, 12'h02C, 32'h00000000, 1'h0},
    '{1'h0, 12'h02C, 32'h0005FF00, 1'h0},
    '{1'h0, 12'h030, 32'h00000000, 1'h1},
    '{1'h1, 12'h010, 32'h000000FF, 1'h0},
    '{1'h0, 12'h018, 32'h000000FF, 1'h0}
  };
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        req = 1'h0;
  logic [2:0]  req_chan = 3'h0;
  logic [9:0]  req_value = 10'h000;
  logic        rx_end = 1'h0;
  logic        rx_full = 1'h0;
  logic        clk_en = 1'h1;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        conv_end;
  logic [2:0]  conv_chan;
  logic [9:0]  conv_value;
  logic [7:0]  chan_en;
  logic        res_sel;
  logic        irq;
  logic [31:0] rd;
  logic        er;
  int          failures = 0;
  int          samples_checked = 0;

  always #50 pclk = ~pclk;

  adcr_engine_model i_eng (.pclk, .presetn, .req, .req_chan, .req_value, .conv_end,
    .conv_chan, .conv_value);
  adcr_top i_dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .conv_end, .conv_chan, .conv_value,
    .receive_count_end_flag(rx_end), .receive_buffers_full_flag(rx_full),
    .channel_enable_bit(chan_en), .resolution_select(res_sel), .irq);

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] v, output logic x);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    chk("pready", 32'h1, {31'h0, pready});
    v = prdata;
    x = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d, rd, er);
  endtask

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0, rd, er);
    chk(nm, e, rd);
  endtask

  // result is settled two edges after the request
  task automatic conv(input logic [2:0] c, input logic [9:0] v);
    @(posedge pclk);
    req       <= 1'h1;
    req_chan  <= c;
    req_value <= v;
    @(posedge pclk);
    req <= 1'h0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(posedge pclk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    irq_is(1'h0);
    chk("chan_en", 32'h0, {24'h0, chan_en});
    foreach (ROWS[i])
    begin
      apb(ROWS[i].wr, ROWS[i].addr, ROWS[i].data, rd, er);
      if (!ROWS[i].wr)
        chk("row data", ROWS[i].data, rd);
      chk("row err", {31'h0, ROWS[i].err}, {31'h0, er});
    end
    wr(12'h028, 32'hFFFFFFFF);
    conv(3'h3, 10'h3FF);
    irq_is(1'h0);
    rd_chk("result 3", 12'h04C, 32'h3FF);
    wr(12'h024, 32'h00010000);
    irq_is(1'h1);
    wr(12'h028, 32'h00010000);
    irq_is(1'h0);
    wr(12'h024, 32'h00040000);
    rx_end <= 1'h1;
    irq_is(1'h1);
    rx_end  <= 1'h0;
    rx_full <= 1'h1;
    irq_is(1'h0);
    rx_full <= 1'h0;
    conv(3'h5, 10'h0AA);
    wr(12'h014, 32'h00000020);
    conv(3'h5, 10'h155);
    conv(3'h2, 10'h2C3);
    rd_chk("result 5", 12'h054, 32'h0AA);
    rd_chk("result 2", 12'h048, 32'h2C3);
    // a conversion that lands while the block is frozen must leave no trace
    clk_en <= 1'h0;
    conv(3'h2, 10'h111);
    clk_en <= 1'h1;
    rd_chk("result 2 frozen", 12'h048, 32'h2C3);
    rd_chk("chan status", 12'h018, 32'hDF);
    wr(12'h004, 32'h00000010);
    conv(3'h1, 10'h3AB);
    chk("res_sel", 32'h1, {31'h0, res_sel});
    rd_chk("result 1", 12'h044, 32'h0AB);
    wr(12'h004, 32'h0);
    conv(3'h1, 10'h3AB);
    rd_chk("result 1", 12'h044, 32'h3AB);
    // reset in mid-run: mask, enables and results return to zero
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    rd_chk("mask after reset", 12'h02C, 32'h0);
    chk("chan_en after reset", 32'h0, {24'h0, chan_en});
    rd_chk("result 1 after reset", 12'h044, 32'h0);
    stop_test;
  end

  initial
  begin
    repeat (3000) @(posedge pclk);
    failures++;
    stop_test;
  end
endmodule
